// ---- arm_pkg.sv ----
// Package with the constants shared by the transmit arming and fault interlock design.
package arm_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_HZ           = 20_000_000;
  localparam int RESET_PULSE_NS   = 2_000;
  localparam int RESET_PULSE_CYC  = (RESET_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1_000;
  localparam int ARM_WINDOW_S     = 2;
  localparam int ARM_WINDOW_CYC   = ARM_WINDOW_S * CLK_HZ;
  localparam int OSC_HZ           = 4_000_000;
  localparam int OSC_DIV          = CLK_HZ / OSC_HZ;
  localparam int DEAD_TICKS       = 8;
  localparam int DEBOUNCE_MS      = 10;
  localparam int DEBOUNCE_CYC     = DEBOUNCE_MS * (CLK_HZ / 1_000);
  localparam int TEST_SLOW_HZ     = 4;
  localparam int TEST_FAST_HZ     = 1024;
  localparam int TEST_SLOW_HALF   = CLK_HZ / (2 * TEST_SLOW_HZ);
  localparam int TEST_FAST_HALF   = CLK_HZ / (2 * TEST_FAST_HZ);

  // ****************************************************************
  // Register map, byte addresses
  // ****************************************************************
  localparam logic [7:0] CTRL_ADDR    = 8'h00;
  localparam logic [7:0] STATUS_ADDR  = 8'h04;
  localparam logic [7:0] FAULT_ADDR   = 8'h08;

  // Control register fields.
  localparam int         CTRL_TEST_LSB  = 0;
  localparam int         CTRL_OSC_BIT   = 2;
  localparam logic [2:0] CTRL_RESET     = 3'h4;

  // Test selector codes; any other code runs normally.
  localparam logic [1:0] TEST_RUN   = 2'h0;
  localparam logic [1:0] TEST_SLOW  = 2'h1;
  localparam logic [1:0] TEST_FAST  = 2'h2;

  // Pin vector layout after synchronisation.
  localparam int PIN_W       = 11;
  localparam int PIN_DRIVE   = 0;
  localparam int PIN_OC_LSB  = 1;
  localparam int PIN_OV      = 5;
  localparam int PIN_IN_OC   = 6;
  localparam int PIN_OPEN    = 7;
  localparam int PIN_HEAT    = 8;
  localparam int PIN_REGLIM  = 9;
  localparam int PIN_SPZERO  = 10;
  // Overcurrent pins rest high (healthy) so that leaving reset does not trip them.
  localparam logic [PIN_W-1:0] PIN_RESET = 11'h01e;

  localparam int NUM_SWITCHES = 4;

endpackage : arm_pkg

// ---- dead_time_if.sv ----
// Interface carrying drive and dead-time signals between the sequencer and its dead-time generator.
`timescale 1ns/100ps
interface dead_time_if;
  logic tick;
  logic drive;
  logic phase_a;
  logic phase_b;
  logic blank;

  modport ctl (output tick, output drive, input phase_a, input phase_b, input blank);
  modport gen (input tick, input drive, output phase_a, output phase_b, output blank);
endinterface : dead_time_if

// ---- switch_debounce.sv ----
// Synchroniser and debouncer for one operator panel switch.
`timescale 1ns/100ps
module switch_debounce
  import arm_pkg::*;
#(
  parameter int STABLE_CYC = DEBOUNCE_CYC
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Raw switch and clean result
  input  wire logic raw_i,
  output logic      level_o,
  output logic      press_o
);

  logic        s1;
  logic        s2;
  logic        s3;
  logic [31:0] stable_cnt;

  // Three stage synchroniser; only s2 and s3 are looked at downstream.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= raw_i;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // A new level is accepted only after it has held for the whole debounce time.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stable_cnt <= 32'h0000_0000;
      level_o    <= 1'b0;
      press_o    <= 1'b0;
    end else begin
      press_o <= 1'b0;
      if (s2 != s3 || s3 == level_o) begin
        stable_cnt <= 32'h0000_0000;
      end else if (stable_cnt >= 32'(STABLE_CYC - 1)) begin
        stable_cnt <= 32'h0000_0000;
        level_o    <= s3;
        press_o    <= s3;
      end else begin
        stable_cnt <= stable_cnt + 32'h0000_0001;
      end
    end
  end

endmodule : switch_debounce

// ---- dead_time_gen.sv ----
// Dead-time generator: two counter halves, one per drive phase, clocked by oscillator ticks.
`timescale 1ns/100ps
module dead_time_gen
  import arm_pkg::*;
#(
  parameter int TICKS = DEAD_TICKS
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Drive request and phase outputs
  dead_time_if.gen  dt
);

  logic       target;
  logic [3:0] cnt_a;
  logic [3:0] cnt_b;

  // A change of requested polarity drops both phases at once and restarts the count.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      target <= 1'b0;
    end else begin
      target <= dt.drive;
    end
  end

  // Phase A half counts while phase B half is held in reset, and the other way round.
  always_ff @(posedge clk_i) begin
    if (rst_i || target != dt.drive) begin
      cnt_a      <= 4'h0;
      cnt_b      <= 4'h0;
      dt.phase_a <= 1'b0;
      dt.phase_b <= 1'b0;
    end else if (target) begin
      cnt_b <= 4'h0;
      if (dt.tick && !dt.phase_a) begin
        if (cnt_a == 4'(TICKS - 1)) begin
          dt.phase_a <= 1'b1;
        end else begin
          cnt_a <= cnt_a + 4'h1;
        end
      end
    end else begin
      cnt_a <= 4'h0;
      if (dt.tick && !dt.phase_b) begin
        if (cnt_b == 4'(TICKS - 1)) begin
          dt.phase_b <= 1'b1;
        end else begin
          cnt_b <= cnt_b + 4'h1;
        end
      end
    end
  end

  // Blanking covers the whole gap; with no ticks the gap never ends, so no drive appears.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dt.blank <= 1'b1;
    end else begin
      dt.blank <= !(dt.phase_a || dt.phase_b) || (target != dt.drive);
    end
  end

endmodule : dead_time_gen

// ---- transmit_arming_and_fault_interlock.sv ----
// Transmit arming sequencer with fault latches, dead time, test drive and a Wishbone register port.
`timescale 1ns/100ps
module transmit_arming_and_fault_interlock
  import arm_pkg::*;
#(
  parameter int ARM_CYC       = ARM_WINDOW_CYC,
  parameter int DEBOUNCE      = DEBOUNCE_CYC,
  parameter int SLOW_HALF_CYC = TEST_SLOW_HALF,
  parameter int FAST_HALF_CYC = TEST_FAST_HALF
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Wishbone slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [7:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  // Operator switches
  input  wire logic             reset_sw_i,
  input  wire logic             transmit_sw_i,
  // Drive request and fault pins
  input  wire logic             drive_cmd_i,
  input  wire logic [3:0]       switch_oc_n_i,
  input  wire logic             overvoltage_i,
  input  wire logic             input_oc_i,
  input  wire logic             open_circuit_i,
  input  wire logic             heat_i,
  input  wire logic             reg_limit_i,
  input  wire logic             setpoint_zero_i,
  // Contactor and switch drive
  output logic                  contactor_o,
  output logic                  phase_a_o,
  output logic                  phase_b_o,
  // Panel indicators
  output logic                  transmit_lamp_o,
  output logic [3:0]            switch_oc_lamp_o,
  output logic                  overvoltage_lamp_o,
  output logic                  input_oc_lamp_o,
  output logic                  open_circuit_lamp_o,
  output logic                  heat_limit_indicator_o,
  output logic                  reg_limit_lamp_o
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  dead_time_if dt ();

  logic [PIN_W-1:0] pin_s1;
  logic [PIN_W-1:0] pin_s2;
  logic [PIN_W-1:0] pin_s3;
  logic [PIN_W-1:0] pin;
  logic             reset_level;
  logic             reset_press;
  logic             transmit_level;
  logic             transmit_press;
  logic [5:0]       clear_cnt;
  logic             clear_pulse;
  logic [31:0]      window_cnt;
  logic             window_open;
  logic [2:0]       osc_div;
  logic             osc_tick;
  logic [1:0]       test_sel;
  logic             osc_run;
  logic [31:0]      test_cnt;
  logic             test_drive;
  logic [3:0]       oc_latch;
  logic             ov_latch;
  logic             in_oc_latch;
  logic             open_latch;
  logic             any_fault;
  logic             accept;
  logic             wb_req;
  logic [31:0]      next_rdata;

  // Field decode shared by the read path and the write path.
  function automatic logic [1:0] reg_index(input logic [7:0] adr);
    unique case (adr)
      CTRL_ADDR:   reg_index = 2'h1;
      STATUS_ADDR: reg_index = 2'h2;
      FAULT_ADDR:  reg_index = 2'h3;
      default:     reg_index = 2'h0;
    endcase
  endfunction : reg_index

  // ****************************************************************
  // Input conditioning
  // ****************************************************************

  // Fault and drive pins: a change is believed once the second and third stages agree.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_s1 <= PIN_RESET;
      pin_s2 <= PIN_RESET;
      pin_s3 <= PIN_RESET;
      pin    <= PIN_RESET;
    end else begin
      pin_s1 <= {setpoint_zero_i, reg_limit_i, heat_i, open_circuit_i, input_oc_i,
                 overvoltage_i, switch_oc_n_i, drive_cmd_i};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin    <= (pin_s2 & pin_s3) | (pin & (pin_s2 ^ pin_s3));
    end
  end

  // Panel switches get a long debounce so that one press is one event.
  switch_debounce #(
    .STABLE_CYC (DEBOUNCE)
  ) u_reset_sw (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .raw_i   (reset_sw_i),
    .level_o (reset_level),
    .press_o (reset_press)
  );

  switch_debounce #(
    .STABLE_CYC (DEBOUNCE)
  ) u_transmit_sw (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .raw_i   (transmit_sw_i),
    .level_o (transmit_level),
    .press_o (transmit_press)
  );

  // ****************************************************************
  // Reset pulse and arming window
  // ****************************************************************

  // One short clear pulse per reset press, regardless of how long the switch is held.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clear_cnt   <= 6'h00;
      clear_pulse <= 1'b0;
    end else if (reset_press) begin
      clear_cnt   <= 6'(RESET_PULSE_CYC - 1);
      clear_pulse <= 1'b1;
    end else if (clear_cnt != 6'h00) begin
      clear_cnt <= clear_cnt - 6'h01;
    end else begin
      clear_pulse <= 1'b0;
    end
  end

  // Transmit is accepted only with the window open, no fault and a non-zero setpoint.
  assign accept = transmit_press && window_open && !any_fault && !clear_pulse
                  && !pin[PIN_SPZERO];

  // Window counts clock cycles and shuts early once transmit is taken.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      window_cnt  <= 32'h0000_0000;
      window_open <= 1'b0;
    end else if (reset_press) begin
      window_cnt  <= 32'(ARM_CYC - 1);
      window_open <= 1'b1;
    end else if (accept) begin
      window_open <= 1'b0;
    end else if (window_cnt != 32'h0000_0000) begin
      window_cnt <= window_cnt - 32'h0000_0001;
    end else begin
      window_open <= 1'b0;
    end
  end

  // ****************************************************************
  // Fault latches
  // ****************************************************************

  // Overcurrent sense is ignored during dead time; a set beats a simultaneous clear.
  genvar g;
  generate
    for (g = 0; g < NUM_SWITCHES; g++) begin : g_oc
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          oc_latch[g] <= 1'b0;
        end else if (!pin[PIN_OC_LSB + g] && !dt.blank) begin
          oc_latch[g] <= 1'b1;
        end else if (clear_pulse) begin
          oc_latch[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // Overvoltage, input overcurrent and open circuit hold until the next reset pulse.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ov_latch    <= 1'b0;
      in_oc_latch <= 1'b0;
      open_latch  <= 1'b0;
    end else begin
      ov_latch    <= pin[PIN_OV] || (ov_latch && !clear_pulse);
      in_oc_latch <= pin[PIN_IN_OC] || (in_oc_latch && !clear_pulse);
      open_latch  <= pin[PIN_OPEN] || (open_latch && !clear_pulse);
    end
  end

  assign any_fault = (|oc_latch) || ov_latch || in_oc_latch || open_latch;

  // ****************************************************************
  // Contactor latch
  // ****************************************************************

  // Faults and reset both open the contactor; the lamp is driven from the same state.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      contactor_o     <= 1'b0;
      transmit_lamp_o <= 1'b0;
    end else if (any_fault || reset_press || clear_pulse) begin
      contactor_o     <= 1'b0;
      transmit_lamp_o <= 1'b0;
    end else if (accept) begin
      contactor_o     <= 1'b1;
      transmit_lamp_o <= 1'b1;
    end
  end

  // ****************************************************************
  // Oscillator, test drive and phase outputs
  // ****************************************************************

  // Divided 4 MHz tick; clearing the run bit stops it, which starves the dead-time count.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_div  <= 3'h0;
      osc_tick <= 1'b0;
    end else if (!osc_run) begin
      osc_div  <= 3'h0;
      osc_tick <= 1'b0;
    end else if (osc_div == 3'(OSC_DIV - 1)) begin
      osc_div  <= 3'h0;
      osc_tick <= 1'b1;
    end else begin
      osc_div  <= osc_div + 3'h1;
      osc_tick <= 1'b0;
    end
  end

  // Internal square wave for bench testing of the drive path.
  always_ff @(posedge clk_i) begin
    if (rst_i || (test_sel != TEST_SLOW && test_sel != TEST_FAST)) begin
      test_cnt   <= 32'h0000_0000;
      test_drive <= 1'b0;
    end else if (test_cnt >= 32'((test_sel == TEST_SLOW) ? SLOW_HALF_CYC - 1 : FAST_HALF_CYC - 1)) begin
      test_cnt   <= 32'h0000_0000;
      test_drive <= !test_drive;
    end else begin
      test_cnt <= test_cnt + 32'h0000_0001;
    end
  end

  assign dt.tick  = osc_tick;
  assign dt.drive = (test_sel == TEST_SLOW || test_sel == TEST_FAST) ? test_drive
                                                                     : pin[PIN_DRIVE];

  dead_time_gen #(
    .TICKS (DEAD_TICKS)
  ) u_dead_time (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .dt    (dt.gen)
  );

  // Switch drive exists only with the contactor closed and nothing latched.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_a_o <= 1'b0;
      phase_b_o <= 1'b0;
    end else begin
      phase_a_o <= dt.phase_a && contactor_o && !any_fault;
      phase_b_o <= dt.phase_b && contactor_o && !any_fault;
    end
  end

  // ****************************************************************
  // Panel indicators
  // ****************************************************************

  // Latched lamps mirror their latches; the status lamps follow their inputs live.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      switch_oc_lamp_o       <= 4'h0;
      overvoltage_lamp_o     <= 1'b0;
      input_oc_lamp_o        <= 1'b0;
      open_circuit_lamp_o    <= 1'b0;
      heat_limit_indicator_o <= 1'b0;
      reg_limit_lamp_o       <= 1'b0;
    end else begin
      switch_oc_lamp_o       <= oc_latch;
      overvoltage_lamp_o     <= ov_latch;
      input_oc_lamp_o        <= in_oc_latch;
      open_circuit_lamp_o    <= open_latch;
      heat_limit_indicator_o <= pin[PIN_HEAT];
      reg_limit_lamp_o       <= pin[PIN_REGLIM] || pin[PIN_SPZERO];
    end
  end

  // ****************************************************************
  // Wishbone register port
  // ****************************************************************

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // Control register; only byte lane 0 carries writable bits.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      test_sel <= CTRL_RESET[CTRL_TEST_LSB +: 2];
      osc_run  <= CTRL_RESET[CTRL_OSC_BIT];
    end else if (wb_req && wb_we_i && wb_sel_i[0] && reg_index(wb_adr_i) == 2'h1) begin
      test_sel <= wb_dat_i[CTRL_TEST_LSB +: 2];
      osc_run  <= wb_dat_i[CTRL_OSC_BIT];
    end
  end

  // Read mux; unmapped addresses read as zero.
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (reg_index(wb_adr_i))
      2'h1:    next_rdata = {29'h0000_0000, osc_run, test_sel};
      2'h2:    next_rdata = {26'h000_0000, dt.phase_b, dt.phase_a, dt.blank, clear_pulse,
                             window_open, contactor_o};
      2'h3:    next_rdata = {23'h00_0000, pin[PIN_REGLIM] || pin[PIN_SPZERO], pin[PIN_HEAT],
                             open_latch, in_oc_latch, ov_latch, oc_latch};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // Every request is answered one cycle later, mapped or not, so the bus never hangs.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        wb_dat_o <= next_rdata;
      end
    end
  end

endmodule : transmit_arming_and_fault_interlock

// ---- interlock_chk.sv ----
// Port checker for the transmit arming and fault interlock.
`timescale 1ns/100ps
module interlock_chk
  import arm_pkg::*;
#(
  parameter int ARM_CYC  = ARM_WINDOW_CYC,
  parameter int DEBOUNCE = DEBOUNCE_CYC
) (
  // Clock and reset
  input wire logic       clk_i,
  input wire logic       rst_i,
  // Watched inputs
  input wire logic       reset_sw_i,
  input wire logic       heat_i,
  input wire logic       reg_limit_i,
  input wire logic       setpoint_zero_i,
  // Watched outputs
  input wire logic       contactor_o,
  input wire logic       transmit_lamp_o,
  input wire logic       phase_a_o,
  input wire logic       phase_b_o,
  input wire logic [3:0] switch_oc_lamp_o,
  input wire logic       overvoltage_lamp_o,
  input wire logic       input_oc_lamp_o,
  input wire logic       heat_limit_indicator_o,
  input wire logic       reg_limit_lamp_o
);
  localparam int MIN_DEAD = CLK_HZ / 1_000_000;
  localparam int CLR_SPAN = DEBOUNCE + 60;
  int since_press;
  int idle;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Cycles since the reset switch was last closed; saturates so that a long run cannot wrap it.
  always_ff @(posedge clk_i) begin
    if (rst_i) since_press <= 32'h4000_0000;
    else if (reset_sw_i) since_press <= 0;
    else if (since_press < 32'h4000_0000) since_press <= since_press + 1;
  end
  // Cycles with both phases off, so a missing dead time shows as a short gap.
  always_ff @(posedge clk_i) begin
    if (rst_i || phase_a_o || phase_b_o) idle <= 0;
    else if (idle < 1000) idle <= idle + 1;
  end
  sequence held2(logic s);
    s [*2];
  endsequence
  sequence steady8(logic s);
    s [*8];
  endsequence
  // ****************************************************************
  // Assertions
  // ****************************************************************
  lamp_follow_a: assert property (transmit_lamp_o == contactor_o)
    else $error("lamp not contactor");
  no_overlap_a: assert property (!(phase_a_o && phase_b_o))
    else $error("phase overlap");
  dead_gap_a: assert property (($rose(phase_a_o) || $rose(phase_b_o)) |-> idle >= MIN_DEAD)
    else $error("no dead time");
  drive_gate_a: assert property ((phase_a_o || phase_b_o) |-> $past(contactor_o))
    else $error("drive while open");
  oc_blocks_a: assert property (held2(|switch_oc_lamp_o) |-> !contactor_o)
    else $error("closed with oc");
  ov_blocks_a: assert property (held2(overvoltage_lamp_o) |-> !contactor_o)
    else $error("closed with ov");
  in_oc_blocks_a: assert property (held2(input_oc_lamp_o) |-> !contactor_o)
    else $error("closed with input oc");
  latch_hold_a: assert property (($fell(input_oc_lamp_o) || $fell(overvoltage_lamp_o)
    || $fell(|switch_oc_lamp_o)) |-> since_press <= CLR_SPAN) else $error("lamp dropped early");
  window_a: assert property ($rose(contactor_o) |-> since_press <= ARM_CYC + 8)
    else $error("closed outside window");
  zero_refuse_a: assert property (steady8(setpoint_zero_i) |-> !$rose(contactor_o))
    else $error("closed at zero");
  reg_lamp_a: assert property (steady8(reg_limit_i || setpoint_zero_i) |-> reg_limit_lamp_o)
    else $error("reg lamp dark");
  heat_lamp_a: assert property (steady8(heat_i) |-> heat_limit_indicator_o)
    else $error("heat lamp dark");
endmodule : interlock_chk

bind transmit_arming_and_fault_interlock interlock_chk #(.ARM_CYC(ARM_CYC), .DEBOUNCE(DEBOUNCE))
  interlock_chk_inst (.*);

// ---- panel_model.sv ----
// Model of the operator panel switches and the isolated switch driver boards.
`timescale 1ns/100ps
module panel_model (
  // Clock
  input  wire logic       clk_i,
  // Desaturation events, one per driver board
  input  wire logic [3:0] desat_i,
  // Switches and fibres
  output logic            reset_sw_o,
  output logic            transmit_sw_o,
  output logic [3:0]      switch_oc_n_o
);
  // A board whose switch leaves saturation darkens its fibre, so a lit fibre means healthy.
  assign switch_oc_n_o = ~desat_i;
  initial begin
    reset_sw_o = 1'b0;
    transmit_sw_o = 1'b0;
  end
  // Holds a switch longer than the debounce filter, then lets go, like a momentary toggle.
  task automatic press(input logic which);
    @(posedge clk_i);
    if (which) transmit_sw_o <= 1'b1;
    else reset_sw_o <= 1'b1;
    repeat (12) @(posedge clk_i);
    transmit_sw_o <= 1'b0;
    reset_sw_o <= 1'b0;
  endtask : press
endmodule : panel_model

// ---- transmit_arming_and_fault_interlock_tb_top.sv ----
// Self-checking testbench for the transmit arming and fault interlock.
`timescale 1ns/100ps
module transmit_arming_and_fault_interlock_tb_top;
  import arm_pkg::*;
  localparam int ARM = 200;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, reset_sw_i, transmit_sw_i, drive_cmd_i;
  logic        overvoltage_i, input_oc_i, open_circuit_i, heat_i, reg_limit_i, setpoint_zero_i;
  logic        contactor_o, phase_a_o, phase_b_o, transmit_lamp_o, overvoltage_lamp_o, input_oc_lamp_o;
  logic        open_circuit_lamp_o, heat_limit_indicator_o, reg_limit_lamp_o;
  logic [7:0]  wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [3:0]  switch_oc_n_i, switch_oc_lamp_o, desat, wb_sel_i;
  int          n_errors, check_count, n;
  // Rows: heat, regulation limit, zero setpoint, then the heat and regulation lamps.
  logic [4:0]  rows[4] = '{5'h12, 5'h09, 5'h05, 5'h00};
  logic [1:0]  modes[3] = '{2'h3, 2'h1, 2'h2};
  int          lo[3] = '{0, 1, 6};
  int          hi[3] = '{0, 2, 9};
  logic [7:0]  flt[4] = '{8'h20, 8'h04, 8'h02, 8'h01};
  transmit_arming_and_fault_interlock #(.ARM_CYC(ARM), .DEBOUNCE(4), .SLOW_HALF_CYC(400), .FAST_HALF_CYC(60))
    transmit_arming_and_fault_interlock_inst (.*);
  panel_model panel_model_inst (.clk_i(clk_i), .desat_i(desat), .reset_sw_o(reset_sw_i),
    .transmit_sw_o(transmit_sw_i), .switch_oc_n_o(switch_oc_n_i));
  // Free-running 20 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  task automatic timeout(input string what);
    n_errors++;
    $display("MISMATCH %s expected event seen timeout", what);
    finish_test();
  endtask : timeout
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One classic Wishbone cycle; the request is held until ack is sampled high.
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] rd);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, adr, dat};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
    @(posedge clk_i);
    if (n >= 20) timeout("ack");
  endtask : wb
  task automatic chk_reg(input string what, input logic [7:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0000_0000, q);
    chk(what, exp, q);
  endtask : chk_reg
  task automatic wait_hi(ref logic s, input string what, input int lim);
    for (int i = 0; i < lim && s !== 1'b1; i++) @(posedge clk_i);
    if (s !== 1'b1) timeout(what);
  endtask : wait_hi
  // Reset press, wait out the clear pulse, then transmit inside the window.
  task automatic arm();
    panel_model_inst.press(1'b0);
    repeat (45) @(posedge clk_i);
    panel_model_inst.press(1'b1);
  endtask : arm
  task automatic count_rises(output int r);
    logic last;
    r = 0;
    last = phase_a_o;
    repeat (900) begin
      @(posedge clk_i);
      if (phase_a_o === 1'b1 && last !== 1'b1) r++;
      last = phase_a_o;
    end
  endtask : count_rises
  function automatic logic [7:0] lamps();
    return 8'({switch_oc_lamp_o, overvoltage_lamp_o, input_oc_lamp_o, open_circuit_lamp_o});
  endfunction : lamps
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, drive_cmd_i, overvoltage_i, input_oc_i, open_circuit_i} = '0;
    {heat_i, reg_limit_i, setpoint_zero_i, wb_adr_i, wb_dat_i, desat} = '0;
    {n_errors, check_count} = '0;
    wb_sel_i = 4'hf;
    rst_i = 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (rows[i]) begin
      {heat_i, reg_limit_i, setpoint_zero_i} <= rows[i][4:2];
      repeat (8) @(posedge clk_i);
      chk("panel lamps", 8'(rows[i][1:0]), 8'({heat_limit_indicator_o, reg_limit_lamp_o}));
    end
    chk("outputs after reset", 32'h0, 32'({contactor_o, phase_a_o, phase_b_o, lamps()}));
    chk_reg("ctrl reset", CTRL_ADDR, 32'h0000_0004);
    chk_reg("fault reset", FAULT_ADDR, 32'h0000_0000);
    wb(1'b1, 8'h0c, 32'hffff_ffff, q);
    chk_reg("unmapped", 8'h0c, 32'h0000_0000);
    // A control write without byte lane 0 must leave the control bits alone.
    wb_sel_i <= 4'he;
    wb(1'b1, CTRL_ADDR, 32'h0000_0000, q);
    wb_sel_i <= 4'hf;
    chk_reg("ctrl kept", CTRL_ADDR, 32'h0000_0004);
    // Refused transmits: after the window, then with a zero setpoint.
    panel_model_inst.press(1'b0);
    repeat (ARM + 50) @(posedge clk_i);
    panel_model_inst.press(1'b1);
    repeat (20) @(posedge clk_i);
    chk("late transmit", 8'h00, 8'(contactor_o));
    setpoint_zero_i <= 1'b1;
    arm();
    repeat (20) @(posedge clk_i);
    chk("zero setpoint", 8'h00, 8'(contactor_o));
    setpoint_zero_i <= 1'b0;
    arm();
    wait_hi(contactor_o, "contactor", 20);
    chk("contactor and lamp", 8'h03, 8'({transmit_lamp_o, contactor_o}));
    drive_cmd_i <= 1'b1;
    wait_hi(phase_a_o, "phase a", 100);
    drive_cmd_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    chk("dead time", 8'h00, 8'({phase_a_o, phase_b_o}));
    wait_hi(phase_b_o, "phase b", 100);
    foreach (modes[i]) begin
      wb(1'b1, CTRL_ADDR, {29'h0, 1'b1, modes[i]}, q);
      count_rises(n);
      chk("test drive", 8'h01, 8'(n >= lo[i] && n <= hi[i]));
    end
    wb(1'b1, CTRL_ADDR, 32'h0000_0000, q);
    drive_cmd_i <= 1'b1;
    repeat (200) @(posedge clk_i);
    chk("stopped oscillator", 8'h00, 8'(phase_a_o));
    wb(1'b1, CTRL_ADDR, 32'h0000_0004, q);
    wait_hi(phase_a_o, "phase restart", 100);
    // Switch 2 overcurrent, overvoltage, input overcurrent and open circuit each trip the contactor, stay latched after they go, and clear on reset.
    for (int k = 0; k < 4; k++) begin
      arm();
      wait_hi(contactor_o, "rearm", 20);
      {desat, overvoltage_i, input_oc_i, open_circuit_i} <= 7'(flt[k]);
      repeat (10) @(posedge clk_i);
      {desat, overvoltage_i, input_oc_i, open_circuit_i} <= '0;
      repeat (10) @(posedge clk_i);
      chk("fault lamps", flt[k], lamps());
      chk("tripped", 8'h00, 8'({transmit_lamp_o, contactor_o, phase_a_o, phase_b_o}));
      panel_model_inst.press(1'b0);
      repeat (60) @(posedge clk_i);
      chk("lamps cleared", 8'h00, lamps());
    end
    finish_test();
  end
endmodule : transmit_arming_and_fault_interlock_tb_top
